// File: hdl/fmc_pkg.sv
// Package of constants and types for the clock-mode controller
package fmc_pkg;

  // Mode codes shared by request and status fields
  typedef enum logic [1:0] {
    MODE_SELF    = 2'b00,
    MODE_ENG_INT = 2'b01,
    MODE_BYP_EXT = 2'b10,
    MODE_ENG_EXT = 2'b11
  } fmc_mode_e;

  localparam logic [1:0] RESET_MODE       = 2'h0;
  localparam int         FACTOR_W         = 3;
  localparam int         CNT_W            = 8;
  localparam int         TRIM_W           = 8;
  localparam int         ERR_W            = 9;
  localparam int         AVG_SAMPLES      = 4;
  localparam logic [2:0] LOCK_SAMPLES     = 3'h3;
  localparam logic [2:0] STATUS_DELAY     = 3'h4;
  localparam logic [ERR_W-1:0] LOCK_WIN   = 9'h002;
  localparam logic [ERR_W-1:0] UNLOCK_WIN = 9'h004;

  // Clock monitor verdicts
  typedef struct packed {
    logic refOk;
    logic dcoOk;
  } fmc_mon_s;

  // Clock routing toward the analog section
  typedef struct packed {
    logic       dcoOn;
    logic       refGenOn;
    logic       useExtRef;
    logic [1:0] outSel;
  } fmc_route_s;

  localparam logic [1:0] OUT_DCO_R   = 2'h0;
  localparam logic [1:0] OUT_DCO_2R  = 2'h1;
  localparam logic [1:0] OUT_EXT_R   = 2'h2;
  localparam logic [1:0] OUT_OFF     = 2'h3;

endpackage : fmc_pkg

// File: hdl/fmc_mode_ctrl.sv
// Mode sequencing, lock detection and clock supervision of the FLL generator
//
// Summary of operation
// - Request 01 on write, or held with stable DCO, enters engaged-internal
// - Engaged-internal uses internal ref, locks factor
// - Enter unlocked when error exceeds unlock window
// - Lock after samples; filter update every tick, every four when locked
// - Three paths into bypassed-external mode
// - Bypass turns oscillator, ref generator off
// - Request 11 with valid, stable enters engaged-external
// - Engaged-external uses external ref, locks factor
// - Engaged-external outputs DCO/2R until first lock
// - Count DCO pulses, subtract factor for error
// - Unexpected excursion sets sticky lock-loss flag
// - Lock-loss flag cleared by ack, reset
// - Stop-off clears lock, keeps lock-loss flag
// - Debug cleared in stop sets flag on wake
// - Factor, mode, internal trim changes: expected loss
// - Monitored clock below threshold sets clock-loss
// - Clock-loss flag cleared by ack, reset
// - Clock loss in engaged-external or bypass forces self-clocked or bypass fallback
// - Clock loss causes lock loss; reset wins
// - Monitoring matrix for engaged and bypass modes
// - Reference valid forced high or low cases
// - Self-clocked monitors DCO only after stable
// - Status field follows selected mode after delay
`timescale 1ns/1ps

module fmc_mode_ctrl (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      modeWrite,
  input  wire logic [1:0]                modeWrData,
  input  wire logic [fmc_pkg::FACTOR_W-1:0] multiplyFactor,
  input  wire logic [fmc_pkg::TRIM_W-1:0] trimValue,
  input  wire logic                      refTypeStatus,
  input  wire logic                      clockMonitorDisable,
  input  wire logic                      lockLossResetEnable,
  input  wire logic                      clockLossResetEnable,
  input  wire logic                      debugEnableBit,
  input  wire logic                      oscInStopEnable,
  input  wire logic                      stopMode,
  input  wire logic                      postStopStartup,
  input  wire logic                      statusRead,
  input  wire logic                      irqFlagWrite,
  input  wire logic                      cmpTick,
  input  wire logic [fmc_pkg::CNT_W-1:0] dcoPulseCount,
  input  wire fmc_pkg::fmc_mon_s         monitorIn,
  output logic [1:0]                     requestedModeField,
  output logic [1:0]                     actualModeStatus,
  output logic                           lockIndicator,
  output logic                           lockLossFlag,
  output logic                           clockLossFlag,
  output logic                           oscStableFlag,
  output logic                           extRefValidFlag,
  output logic                           genIrqRequest,
  output logic                           chipResetRequest,
  output logic                           filterUpdate,
  output logic [fmc_pkg::ERR_W+1:0]      filterStep,
  output fmc_pkg::fmc_route_s            route
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers for monitor verdicts
  fmc_pkg::fmc_mon_s monMeta_q;
  fmc_pkg::fmc_mon_s monSync_q;

  always_ff @(posedge clk)
  begin
    monMeta_q <= monitorIn;
    monSync_q <= monMeta_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_OFF  = 2'b01,
    ST_WAKE = 2'b10
  } fmc_pwr_e;

  fmc_pwr_e                     pwr_q;
  fmc_pkg::fmc_mode_e           mode_q, mode_d;
  logic [1:0]                   req_q, req_d;
  logic [1:0]                   stat_q;
  logic [2:0]                   statDly_q;
  logic                         locked_q, everLocked_q;
  logic [2:0]                   lockCnt_q;
  logic [1:0]                   avgCnt_q;
  logic signed [fmc_pkg::ERR_W+1:0] errSum_q;
  logic [fmc_pkg::FACTOR_W-1:0] factor_q;
  logic [fmc_pkg::TRIM_W-1:0]   trim_q;
  logic                         dcoStable_q, dcoStableSeen_q;
  logic                         lol_q, loc_q, ackArmed_q;
  logic                         dbgLostInStop_q, offExtReq_q, dbgHeld_q;

  ////////////////////////////////////////////////////////////////////////////
  // Error and window decode
  wire logic signed [fmc_pkg::ERR_W-1:0] countErr =
    $signed({1'b0, dcoPulseCount}) - $signed({{(fmc_pkg::ERR_W-fmc_pkg::FACTOR_W){1'b0}},
    multiplyFactor});
  wire logic signed [fmc_pkg::ERR_W-1:0] lockWin   = $signed(fmc_pkg::LOCK_WIN);
  wire logic signed [fmc_pkg::ERR_W-1:0] unlockWin = $signed(fmc_pkg::UNLOCK_WIN);
  wire logic inLockWin   = (countErr <= lockWin) && (countErr >= -lockWin);
  wire logic inUnlockWin = (countErr <= unlockWin) && (countErr >= -unlockWin);

  wire logic engaged  = (mode_q == fmc_pkg::MODE_ENG_INT) || (mode_q == fmc_pkg::MODE_ENG_EXT);
  wire logic running  = (pwr_q == ST_RUN);
  wire logic keepRun  = debugEnableBit || oscInStopEnable;
  wire logic goOff    = running && stopMode && !keepRun;
  // Debug dropped while already stopped
  wire logic dbgDrop  = running && stopMode && !debugEnableBit && dbgHeld_q;

  // Expected losses of lock
  wire logic expLoss  = (multiplyFactor != factor_q) || (modeWrite && modeWrData != req_q) ||
                        ((mode_q == fmc_pkg::MODE_ENG_INT) && trimValue != trim_q);

  ////////////////////////////////////////////////////////////////////////////
  // Monitoring matrix
  wire logic refMonitored =
    !clockMonitorDisable &&
    (((mode_q == fmc_pkg::MODE_ENG_EXT) || req_q == 2'b11) ||
     (req_q == 2'b10 && refTypeStatus));
  wire logic dcoMonitored =
    !clockMonitorDisable && running && (mode_q != fmc_pkg::MODE_BYP_EXT) &&
    ((mode_q != fmc_pkg::MODE_SELF) || dcoStableSeen_q);
  wire logic refLost = running && refMonitored && !monSync_q.refOk;
  wire logic dcoLost = dcoMonitored && !monSync_q.dcoOk;
  wire logic clkLoss = refLost || dcoLost;

  wire logic extValid =
    (pwr_q != ST_RUN) ? (req_q == 2'b10 && refTypeStatus && postStopStartup &&
                         monSync_q.refOk) :
    (req_q[1] == 1'b0) ? 1'b0 :
    (req_q == 2'b10 && !refTypeStatus) ? 1'b1 :
    monSync_q.refOk;

  wire logic unexpLoss = running && engaged && locked_q && !expLoss &&
                         ((cmpTick && !inUnlockWin) || clkLoss);
  wire logic wakeLoss  = (pwr_q == ST_WAKE) && dbgLostInStop_q;
  wire logic ackClear  = ackArmed_q && irqFlagWrite;

  ////////////////////////////////////////////////////////////////////////////
  // Mode selection
  always_comb
  begin
    mode_d = mode_q;
    req_d  = modeWrite ? modeWrData : req_q;
    if (pwr_q == ST_WAKE)
    begin
      if (offExtReq_q && extValid)
        mode_d = fmc_pkg::MODE_BYP_EXT;
      else
        mode_d = fmc_pkg::MODE_SELF;
    end
    else if (running)
    begin
      unique case (mode_q)
        fmc_pkg::MODE_ENG_EXT:
          if (refLost)
          begin
            mode_d = fmc_pkg::MODE_SELF;
            req_d  = 2'b00;
          end
          else if (dcoLost)
          begin
            mode_d = fmc_pkg::MODE_BYP_EXT;
            req_d  = 2'b10;
          end
          else if (req_d != 2'b11)
            mode_d = (req_d == 2'b10 && extValid) ? fmc_pkg::MODE_BYP_EXT
                   : (req_d == 2'b01) ? fmc_pkg::MODE_ENG_INT : fmc_pkg::MODE_SELF;
        fmc_pkg::MODE_BYP_EXT:
          if (refLost)
          begin
            mode_d = fmc_pkg::MODE_SELF;
            req_d  = 2'b00;
          end
          else if (req_d != 2'b10)
            mode_d = (req_d == 2'b01) ? fmc_pkg::MODE_ENG_INT : fmc_pkg::MODE_SELF;
        default:
          if (req_d == 2'b01 && (modeWrite || dcoStable_q))
            mode_d = fmc_pkg::MODE_ENG_INT;
          else if (req_d == 2'b10 && extValid)
            mode_d = fmc_pkg::MODE_BYP_EXT;
          else if (req_d == 2'b11 && extValid && dcoStable_q)
            mode_d = fmc_pkg::MODE_ENG_EXT;
          else if (req_d == 2'b00)
            mode_d = fmc_pkg::MODE_SELF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state, mode and delayed status
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pwr_q           <= ST_RUN;
      mode_q          <= fmc_pkg::MODE_SELF;
      req_q           <= fmc_pkg::RESET_MODE;
      stat_q          <= fmc_pkg::RESET_MODE;
      statDly_q       <= 3'h0;
      dbgLostInStop_q <= 1'b0;
      offExtReq_q     <= 1'b0;
    end
    else
    begin
      req_q  <= req_d;
      mode_q <= goOff ? mode_q : mode_d;
      unique case (pwr_q)
        ST_RUN:
          if (goOff || dbgDrop)
          begin
            pwr_q           <= ST_OFF;
            dbgLostInStop_q <= dbgDrop;
            offExtReq_q     <= (req_q == 2'b10) && extValid;
          end
        ST_OFF:
          if (!stopMode)
            pwr_q <= ST_WAKE;
        ST_WAKE:
        begin
          pwr_q           <= ST_RUN;
          dbgLostInStop_q <= 1'b0;
        end
        default:
          pwr_q <= ST_RUN;
      endcase
      if (mode_d != fmc_pkg::fmc_mode_e'(stat_q))
      begin
        statDly_q <= statDly_q + 3'h1;
        if (statDly_q == fmc_pkg::STATUS_DELAY)
        begin
          stat_q    <= mode_d;
          statDly_q <= 3'h0;
        end
      end
      else
        statDly_q <= 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock detector, averaging and DCO stability
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      locked_q        <= 1'b0;
      everLocked_q    <= 1'b0;
      lockCnt_q       <= 3'h0;
      avgCnt_q        <= 2'h0;
      errSum_q        <= '0;
      factor_q        <= '0;
      trim_q          <= '0;
      dcoStable_q     <= 1'b0;
      dcoStableSeen_q <= 1'b0;
      filterUpdate    <= 1'b0;
      filterStep      <= '0;
    end
    else
    begin
      factor_q     <= multiplyFactor;
      trim_q       <= trimValue;
      filterUpdate <= 1'b0;
      if (pwr_q != ST_RUN)
        dcoStable_q <= 1'b0;
      else if (cmpTick)
        dcoStable_q <= inUnlockWin && monSync_q.dcoOk;
      if (mode_d == fmc_pkg::MODE_SELF && mode_q != fmc_pkg::MODE_SELF || pwr_q == ST_WAKE)
        dcoStableSeen_q <= 1'b0;
      else if (dcoStable_q)
        dcoStableSeen_q <= 1'b1;
      if (!engaged || goOff || expLoss || unexpLoss || mode_d != mode_q)
      begin
        locked_q  <= 1'b0;
        lockCnt_q <= 3'h0;
        avgCnt_q  <= 2'h0;
        errSum_q  <= '0;
        if (mode_d != fmc_pkg::MODE_ENG_EXT || mode_q != fmc_pkg::MODE_ENG_EXT || expLoss)
          everLocked_q <= 1'b0;
      end
      else if (cmpTick && !locked_q)
      begin
        filterUpdate <= 1'b1;
        filterStep   <= (fmc_pkg::ERR_W+2)'(countErr);
        lockCnt_q    <= inLockWin ? lockCnt_q + 3'h1 : 3'h0;
        if (inLockWin && lockCnt_q == fmc_pkg::LOCK_SAMPLES - 3'h1)
        begin
          locked_q     <= 1'b1;
          everLocked_q <= 1'b1;
        end
      end
      else if (cmpTick)
      begin
        errSum_q <= (avgCnt_q == 2'(fmc_pkg::AVG_SAMPLES - 1)) ? '0
                  : errSum_q + (fmc_pkg::ERR_W+2)'(countErr);
        avgCnt_q <= avgCnt_q + 2'h1;
        if (avgCnt_q == 2'(fmc_pkg::AVG_SAMPLES - 1))
        begin
          filterUpdate <= 1'b1;
          filterStep   <= (errSum_q + (fmc_pkg::ERR_W+2)'(countErr)) >>> 2;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags and outputs
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      lol_q      <= 1'b0;
      loc_q      <= 1'b0;
      ackArmed_q <= 1'b0;
      dbgHeld_q  <= 1'b0;
    end
    else
    begin
      dbgHeld_q <= stopMode && debugEnableBit;
      if (statusRead)
        ackArmed_q <= 1'b1;
      else if (irqFlagWrite)
        ackArmed_q <= 1'b0;
      if (unexpLoss || wakeLoss)
        lol_q <= 1'b1;
      else if (ackClear && !lockLossResetEnable)
        lol_q <= 1'b0;
      if (clkLoss)
        loc_q <= 1'b1;
      else if (ackClear && !clockLossResetEnable)
        loc_q <= 1'b0;
    end
  end

  wire logic resetReq = (lol_q && lockLossResetEnable) || (loc_q && clockLossResetEnable);
  wire logic irqReq   = !resetReq &&
                        ((lol_q && !lockLossResetEnable) || (loc_q && !clockLossResetEnable));

  fmc_pkg::fmc_route_s routeD;
  always_comb
  begin
    routeD = '{dcoOn: 1'b1, refGenOn: 1'b1, useExtRef: 1'b0, outSel: fmc_pkg::OUT_DCO_R};
    if (pwr_q != ST_RUN)
      routeD = '{dcoOn: keepRun, refGenOn: keepRun, useExtRef: 1'b0, outSel: fmc_pkg::OUT_OFF};
    else if (mode_q == fmc_pkg::MODE_BYP_EXT)
      routeD = '{dcoOn: 1'b0, refGenOn: 1'b0, useExtRef: 1'b1,
                 outSel: fmc_pkg::OUT_EXT_R};
    else if (mode_q == fmc_pkg::MODE_ENG_EXT)
      routeD = '{dcoOn: 1'b1, refGenOn: 1'b0, useExtRef: 1'b1,
                 outSel: everLocked_q ? fmc_pkg::OUT_DCO_R : fmc_pkg::OUT_DCO_2R};
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      requestedModeField <= fmc_pkg::RESET_MODE;
      actualModeStatus   <= fmc_pkg::RESET_MODE;
      lockIndicator      <= 1'b0;
      lockLossFlag       <= 1'b0;
      clockLossFlag      <= 1'b0;
      oscStableFlag      <= 1'b0;
      extRefValidFlag    <= 1'b0;
      genIrqRequest      <= 1'b0;
      chipResetRequest   <= 1'b0;
      route              <= '{dcoOn: 1'b1, refGenOn: 1'b1, useExtRef: 1'b0,
                              outSel: fmc_pkg::OUT_DCO_R};
    end
    else
    begin
      requestedModeField <= req_q;
      actualModeStatus   <= stat_q;
      lockIndicator      <= locked_q;
      lockLossFlag       <= lol_q;
      clockLossFlag      <= loc_q;
      oscStableFlag      <= dcoStable_q;
      extRefValidFlag    <= extValid;
      genIrqRequest      <= irqReq;
      chipResetRequest   <= resetReq;
      route              <= routeD;
    end
  end

endmodule : fmc_mode_ctrl

// File: verif/fmc_mode_ctrl_properties.sv
// Concurrent checks on the ports of the clock-mode controller
`timescale 1ns/1ps

module fmc_mode_ctrl_checker (
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic                modeWrite,
  input wire logic [1:0]          modeWrData,
  input wire logic                refTypeStatus,
  input wire logic                clockMonitorDisable,
  input wire logic                lockLossResetEnable,
  input wire logic                clockLossResetEnable,
  input wire logic                irqFlagWrite,
  input wire logic                cmpTick,
  input wire fmc_pkg::fmc_mon_s   monitorIn,
  input wire logic [1:0]          requestedModeField,
  input wire logic [1:0]          actualModeStatus,
  input wire logic                lockIndicator,
  input wire logic                lockLossFlag,
  input wire logic                clockLossFlag,
  input wire logic                extRefValidFlag,
  input wire logic                genIrqRequest,
  input wire logic                chipResetRequest,
  input wire fmc_pkg::fmc_route_s route
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  sequence ackRecent;
    $past(irqFlagWrite) || $past(irqFlagWrite, 2) || $past(irqFlagWrite, 3);
  endsequence
  sequence tickRecent;
    $past(cmpTick) || $past(cmpTick, 2) || $past(cmpTick, 3);
  endsequence
  sequence irqEnablesOff;
    !lockLossResetEnable && !clockLossResetEnable;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  lock_flag_hold_a: assert property ($fell(lockLossFlag) |-> ackRecent)
    else $error("lock-loss flag dropped without ack");
  clock_flag_hold_a: assert property ($fell(clockLossFlag) |-> ackRecent)
    else $error("clock-loss flag dropped without ack");
  lock_after_tick_a: assert property ($rose(lockIndicator) |-> tickRecent)
    else $error("lock rose away from a comparison");
  irq_raise_a: assert property ($rose(lockLossFlag) ##0 irqEnablesOff |-> ##[0:2] genIrqRequest)
    else $error("interrupt request missing");
  reset_wins_a: assert property ($rose(lockLossFlag) && lockLossResetEnable
    |-> ##[0:2] chipResetRequest)
    else $error("chip reset request missing");
  status_delay_a: assert property (modeWrite |=> $stable(actualModeStatus) [*2])
    else $error("mode status moved at once");
  fei_entry_a: assert property (modeWrite && modeWrData == 2'h1
    |-> ##[3:12] actualModeStatus == fmc_pkg::MODE_ENG_INT)
    else $error("engaged-internal not entered");
  bypass_route_a: assert property ($rose(actualModeStatus == fmc_pkg::MODE_BYP_EXT)
    |-> ##[0:2] (!route.dcoOn && !route.refGenOn && route.outSel == fmc_pkg::OUT_EXT_R))
    else $error("bypass routing wrong");
  fee_half_a: assert property ($rose(actualModeStatus == fmc_pkg::MODE_ENG_EXT) && !lockIndicator
    |-> ##[0:2] (route.useExtRef && route.outSel == fmc_pkg::OUT_DCO_2R))
    else $error("engaged-external routing wrong");
  ref_forced_low_a: assert property (!requestedModeField[1] && !$past(requestedModeField[1], 3)
    && !actualModeStatus[1] |-> !extRefValidFlag)
    else $error("reference valid not forced low");
  ref_loss_a: assert property (actualModeStatus[1] && !monitorIn.refOk && refTypeStatus
    && !clockMonitorDisable |-> ##[1:16] actualModeStatus == fmc_pkg::MODE_SELF)
    else $error("no fallback on reference loss");
  dco_loss_a: assert property (actualModeStatus == fmc_pkg::MODE_ENG_EXT && !monitorIn.dcoOk
    && monitorIn.refOk && !clockMonitorDisable
    |-> ##[1:16] actualModeStatus == fmc_pkg::MODE_BYP_EXT)
    else $error("no bypass on oscillator loss");
endmodule : fmc_mode_ctrl_checker

// File: verif/tb.sv
// Self-checking bench for the clock-mode controller
`timescale 1ns/1ps

module tb;
  logic                      clk = 1'b0;
  logic                      reset_n = 1'b0;
  logic                      modeWrite = 1'b0;
  logic [1:0]                modeWrData = 2'h0;
  logic [fmc_pkg::FACTOR_W-1:0] multiplyFactor = 3'h5;
  logic [7:0]                trimValue = 8'h80;
  logic                      refTypeStatus = 1'b1;
  logic                      clockMonitorDisable = 1'b0;
  logic                      lockLossResetEnable = 1'b0;
  logic                      clockLossResetEnable = 1'b0;
  logic                      debugEnableBit = 1'b0;
  logic                      oscInStopEnable = 1'b0;
  logic                      stopMode = 1'b0;
  logic                      postStopStartup = 1'b0;
  logic                      statusRead = 1'b0;
  logic                      irqFlagWrite = 1'b0;
  logic                      cmpTick = 1'b0;
  logic [7:0]                dcoPulseCount = 8'h00;
  fmc_pkg::fmc_mon_s         monitorIn = 2'h3;
  logic [1:0]                requestedModeField;
  logic [1:0]                actualModeStatus;
  logic                      lockIndicator;
  logic                      lockLossFlag;
  logic                      clockLossFlag;
  logic                      oscStableFlag;
  logic                      extRefValidFlag;
  logic                      genIrqRequest;
  logic                      chipResetRequest;
  logic                      filterUpdate;
  logic [fmc_pkg::ERR_W+1:0] filterStep;
  fmc_pkg::fmc_route_s       route;
  int                        miscompares = 0;
  int                        nCompared = 0;
  int                        nUpd = 0;
  localparam logic [7:0]     GOOD = 8'h05;
  localparam logic [7:0]     BAD = 8'h0C;

  fmc_mode_ctrl dut (.clk, .reset_n, .modeWrite, .modeWrData, .multiplyFactor, .trimValue,
    .refTypeStatus, .clockMonitorDisable, .lockLossResetEnable, .clockLossResetEnable,
    .debugEnableBit, .oscInStopEnable, .stopMode, .postStopStartup, .statusRead,
    .irqFlagWrite, .cmpTick, .dcoPulseCount, .monitorIn, .requestedModeField,
    .actualModeStatus, .lockIndicator, .lockLossFlag, .clockLossFlag, .oscStableFlag,
    .extRefValidFlag, .genIrqRequest, .chipResetRequest, .filterUpdate, .filterStep, .route);

  always #5 clk = ~clk;
  always @(posedge clk) if (filterUpdate === 1'b1) nUpd <= nUpd + 1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic doReset;
    reset_n = 1'b0;
    cyc(20);
    reset_n = 1'b1;
    cyc(2);
  endtask : doReset
  task automatic writeMode(input logic [1:0] m);
    modeWrite = 1'b1;
    modeWrData = m;
    cyc(1);
    modeWrite = 1'b0;
    cyc(12);
  endtask : writeMode
  task automatic ticks(input int n, input logic [7:0] cnt);
    repeat (n)
    begin
      cmpTick = 1'b1;
      dcoPulseCount = cnt;
      cyc(1);
      cmpTick = 1'b0;
      cyc(4);
    end
    cyc(3);
  endtask : ticks
  task automatic ack;
    statusRead = 1'b1;
    cyc(1);
    statusRead = 1'b0;
    irqFlagWrite = 1'b1;
    cyc(1);
    irqFlagWrite = 1'b0;
    cyc(4);
  endtask : ack
  task automatic test_done;
    $display("compared %0d mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  task automatic testFeiLock;
    doReset();
    check({route, actualModeStatus, lockLossFlag}, 8'hC0);
    writeMode(2'h1);
    check({actualModeStatus, route.useExtRef, route.outSel}, 8'h08);
    ticks(5, GOOD);
    check(lockIndicator, 8'h01);
    nUpd = 0;
    ticks(8, GOOD);
    check(8'(nUpd), 8'h02);
    ticks(1, BAD);
    check({lockIndicator, lockLossFlag, genIrqRequest}, 8'h03);
    irqFlagWrite = 1'b1;
    cyc(1);
    irqFlagWrite = 1'b0;
    cyc(4);
    check(lockLossFlag, 8'h01);
    ack();
    check(lockLossFlag, 8'h00);
    ticks(5, GOOD);
    trimValue = 8'h3C;
    cyc(6);
    check({lockIndicator, lockLossFlag}, 8'h00);
    ticks(5, GOOD);
    stopMode = 1'b1;
    cyc(6);
    check({lockIndicator, lockLossFlag}, 8'h00);
    stopMode = 1'b0;
    cyc(4);
  endtask : testFeiLock

  task automatic testClkAck;
    doReset();
    writeMode(2'h1);
    ticks(1, 8'h07);
    check(filterStep[7:0], 8'h02);
    check(oscStableFlag, 8'h01);
    clockMonitorDisable = 1'b1;
    monitorIn.dcoOk = 1'b0;
    cyc(8);
    check(clockLossFlag, 8'h00);
    clockMonitorDisable = 1'b0;
    cyc(8);
    check({clockLossFlag, genIrqRequest}, 8'h03);
    monitorIn.dcoOk = 1'b1;
    cyc(4);
    ack();
    check(clockLossFlag, 8'h00);
    debugEnableBit = 1'b1;
    stopMode = 1'b1;
    cyc(4);
    debugEnableBit = 1'b0;
    cyc(4);
    stopMode = 1'b0;
    cyc(6);
    check(lockLossFlag, 8'h01);
  endtask : testClkAck

  task automatic testFee;
    doReset();
    lockLossResetEnable = 1'b1;
    writeMode(2'h1);
    ticks(5, GOOD);
    writeMode(2'h3);
    check({actualModeStatus, route.useExtRef, route.outSel}, 8'h1D);
    ticks(5, GOOD);
    check({lockIndicator, route.outSel}, 8'h04);
    monitorIn.dcoOk = 1'b0;
    cyc(16);
    check({actualModeStatus, requestedModeField}, 8'h0A);
    check({route.dcoOn, route.refGenOn, route.outSel}, 8'h02);
    check({clockLossFlag, lockLossFlag, chipResetRequest, genIrqRequest}, 8'h0E);
    monitorIn.refOk = 1'b0;
    cyc(20);
    check({actualModeStatus, extRefValidFlag}, 8'h00);
    doReset();
    check({clockLossFlag, lockLossFlag, chipResetRequest}, 8'h00);
    monitorIn = 2'h3;
    lockLossResetEnable = 1'b0;
  endtask : testFee

  initial
  begin
    testFeiLock();
    testClkAck();
    testFee();
    test_done();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule : tb

bind fmc_mode_ctrl fmc_mode_ctrl_checker chk (.clk, .reset_n, .modeWrite, .modeWrData,
  .refTypeStatus, .clockMonitorDisable, .lockLossResetEnable, .clockLossResetEnable,
  .irqFlagWrite, .cmpTick, .monitorIn, .requestedModeField, .actualModeStatus,
  .lockIndicator, .lockLossFlag, .clockLossFlag, .extRefValidFlag, .genIrqRequest,
  .chipResetRequest, .route);
